// ---- core/flash_cmd_pkg.sv ----
`default_nettype none
package flash_cmd_pkg;

   // Opcodes handled by this front end
   localparam logic [7:0] NOP_COMMAND = 8'h00;
   localparam logic [7:0] RESET_ARM_COMMAND = 8'h66;
   localparam logic [7:0] RESET_COMMAND = 8'h99;
   localparam logic [7:0] QUAD_ENABLE_COMMAND = 8'h38;
   localparam logic [7:0] QUAD_EXIT_COMMAND = 8'hFF;
   localparam logic [7:0] READ_COMMAND = 8'h03;
   localparam logic [7:0] FAST_READ_COMMAND = 8'h0B;

   // Last sck edge of a byte, counted from zero
   localparam logic [2:0] QUAD_LAST_EDGE = 3'h1;
   localparam logic [2:0] SINGLE_LAST_EDGE = 3'h7;

   // Frame layout
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [1:0] SINGLE_DUMMY_BYTES = 2'h1;
   localparam logic [1:0] QUAD_DUMMY_BYTES = 2'h2;
   localparam logic [3:0] CONT_MODE_NIBBLE = 4'hA;
   localparam logic [7:0] LOCKED_DATA = 8'h00;

   // Array geometry
   localparam int unsigned ARRAY_AW_DEFAULT = 23;
   localparam int unsigned LOCK_BLOCK_AW = 16;

   // Reset values and masks of the system-side registers
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] STATUS_KEEP_MASK = 8'h30;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] CONFIG_IO_MASK = 8'h02;
   localparam logic [1:0] BURST_RESET = 2'h0;

   // Frame phases
   typedef enum logic [2:0]
   {
      PH_FIRST,
      PH_ADDR,
      PH_MODE,
      PH_DUMMY,
      PH_DATA,
      PH_IGNORE
   } phase_t;

endpackage
`default_nettype wire

// ---- core/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync2
#(
   parameter int unsigned WIDTH = 1
)
(
   // Destination clock
   input wire logic clk,
   // Level from the other domain
   input wire logic [WIDTH-1:0] d,
   // Synchronised level
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // Two stages; only the second stage reads the first
   always_ff @(posedge clk)
   begin
      meta <= d;
      q <= meta;
   end

endmodule
`default_nettype wire

// ---- core/flash_array_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_array_mem
#(
   parameter int unsigned AW = 23,
   parameter int unsigned DW = 8
)
(
   // Load port
   input wire logic wr_clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic rd_clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   logic [DW-1:0] cells [0:(1<<AW)-1];

   // Load from the system side
   always_ff @(posedge wr_clk)
   begin
      if (we)
      begin
         cells[waddr] <= wdata;
      end
   end

   // Registered read, held until the next enabled read
   always_ff @(posedge rd_clk)
   begin
      if (rd_en)
      begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule
`default_nettype wire

// ---- core/flash_cmd_front_end.sv ----
// What this block does
// R1 - Opcode: two clocks quad, eight single-bit.
// R2 - Other bytes: two clocks quad, eight single-bit.
// R3 - Address bits above the array's top bit are ignored.
// R4 - Reset runs only right after reset-arm; others cancel the arm.
// R5 - Host sends reset-arm and reset as two separate frames.
// R6 - No-operation only cancels a pending reset-arm.
// R7 - Reset: single-bit, burst 8, status defaults but bits 4,5, cfg 1 clear.
// R8 - Reset aborts a running program or erase.
// R9 - Plain read only in single-bit protocol.
// R10 - Plain read: opcode, 24-bit address, data at once, no dummy.
// R11 - Raising select ends the read data stream.
// R12 - Read address steps per byte, wrapping to zero past the top.
// R13 - Quad-enable switches to quad protocol until quad-exit, reset or power cycle.
// R14 - Quad-exit returns to single-bit from either protocol.
// R15 - In continuous mode first quad-exit only leaves that mode.
// R16 - Host drives unused upper lines valid in single-bit frames.
// R17 - Single-bit fast read: opcode, 3 address, one dummy, data.
// R18 - Quad fast read: opcode, 3 address, mode, 2 dummy; high nibble first.
// R19 - Quad read data nibbles launch on falling sck edges.
// R20 - Quad fast read returns zero for bytes in read-locked blocks.
// R21 - Mode nibble A: next frame starts with address, no opcode.
// R22 - Any other mode nibble: next frame starts with an opcode.
// R23 - Power-up starts in single-bit protocol.
// R24 - Rising sck samples; select rise abandons unfinished frames.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_front_end
   import flash_cmd_pkg::*;
#(
   parameter int unsigned ARRAY_AW = flash_cmd_pkg::ARRAY_AW_DEFAULT,
   parameter int unsigned LOCK_BLOCKS =
      1 << (ARRAY_AW - flash_cmd_pkg::LOCK_BLOCK_AW)
)
(
   // System clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Serial link from the host
   input wire logic sck,
   input wire logic chip_sel_n,
   input wire logic [3:0] serial_io_lines_in,
   output logic [3:0] serial_io_lines_out,
   output logic [3:0] serial_io_lines_oe,
   // Array load port, mclk domain
   input wire logic mem_we,
   input wire logic [ARRAY_AW-1:0] mem_waddr,
   input wire logic [7:0] mem_wdata,
   // Read-lock map, one bit per block, mclk domain
   input wire logic [LOCK_BLOCKS-1:0] read_lock,
   // Program or erase in progress
   input wire logic program_busy,
   // Register writes from the rest of the device
   input wire logic status_we,
   input wire logic [7:0] status_wdata,
   input wire logic config_we,
   input wire logic [7:0] config_wdata,
   input wire logic burst_we,
   input wire logic [1:0] burst_wdata,
   // Register and event outputs
   output logic [7:0] status_reg,
   output logic [7:0] config_reg,
   output logic [1:0] burst_len,
   output logic quad_mode,
   output logic sw_reset_pulse,
   output logic abort_program
);

   import flash_cmd_pkg::*;

   // Bit or nibble for the current data edge
   function automatic logic [3:0] out_lines(input logic [7:0] b,
                                            input logic [2:0] edge_cnt,
                                            input logic is_quad);
      logic [3:0] r;
      r = 4'h0;
      if (is_quad)
      begin
         r = edge_cnt[0] ? b[3:0] : b[7:4];
      end
      else
      begin
         r = {2'b00, b[~edge_cnt], 1'b0};
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Link-domain reset and lock map crossing
   ////////////////////////////////////////////////////////////////////////

   logic link_rst;
   logic [LOCK_BLOCKS-1:0] lock_sync;

   // Reset reaches the link logic only while sck toggles
   sync2 #(.WIDTH(1)) u_link_rst
   (
      .clk(sck),
      .d(srst),
      .q(link_rst)
   );

   // Lock map is quasi-static; per-bit sync is enough
   sync2 #(.WIDTH(LOCK_BLOCKS)) u_lock_sync
   (
      .clk(sck),
      .d(read_lock),
      .q(lock_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Link-domain state
   ////////////////////////////////////////////////////////////////////////

   // Persistent across frames
   logic quad;
   logic cont;
   logic arm;
   logic rst_tgl;

   // Per frame, cleared while select is high
   phase_t phase;
   phase_t next_phase;
   logic [2:0] bcnt;
   logic [1:0] bidx;
   logic [7:0] shreg;
   logic fast;
   logic [23:0] addr_acc;
   logic [ARRAY_AW-1:0] ptr;
   logic lock_q;

   // Array read port
   logic rd_en;
   logic [ARRAY_AW-1:0] rd_addr;
   logic [7:0] mem_rdata;
   logic [7:0] byte_out;

   ////////////////////////////////////////////////////////////////////////
   // Byte assembly
   ////////////////////////////////////////////////////////////////////////

   wire [7:0] byte_w;
   wire [2:0] last_edge;
   wire byte_done;
   wire [23:0] addr_next;

   // R2 byte width
   assign byte_w = quad ? {shreg[3:0], serial_io_lines_in}
                        : {shreg[6:0], serial_io_lines_in[0]};
   // R1 opcode width
   assign last_edge = quad ? QUAD_LAST_EDGE : SINGLE_LAST_EDGE;
   assign byte_done = (bcnt == last_edge);
   // R18 high nibble first
   assign addr_next = {addr_acc[15:0], byte_w};

   ////////////////////////////////////////////////////////////////////////
   // Command decode
   ////////////////////////////////////////////////////////////////////////

   wire first_done;
   wire is_cmd;
   wire exec_arm;
   wire exec_reset;
   wire exec_quad_en;
   wire exec_quad_exit;
   wire cont_exit;
   wire cont_addr;
   wire start_read;
   wire start_fast;
   wire addr_last;
   wire mode_done;
   wire [1:0] dummy_need;
   wire dummy_last;
   wire enter_data;
   wire data_step;

   assign first_done = (phase == PH_FIRST) && byte_done;
   // R22 opcode expected when not continuous
   assign is_cmd = first_done && !cont;
   assign exec_arm = is_cmd && (byte_w == RESET_ARM_COMMAND);
   // R4 reset needs the arm
   assign exec_reset = is_cmd && (byte_w == RESET_COMMAND) && arm;
   // R13 quad enable from single-bit only
   assign exec_quad_en = is_cmd && (byte_w == QUAD_ENABLE_COMMAND) && !quad;
   // R14 exit in either protocol
   assign exec_quad_exit = is_cmd && (byte_w == QUAD_EXIT_COMMAND);
   // R15 first exit leaves continuous mode
   assign cont_exit = first_done && cont && (byte_w == QUAD_EXIT_COMMAND);
   // R21 frame opens on the address
   assign cont_addr = first_done && cont && !cont_exit;
   // R9 plain read single-bit only
   assign start_read = is_cmd && (byte_w == READ_COMMAND) && !quad;
   assign start_fast = is_cmd && (byte_w == FAST_READ_COMMAND);
   assign addr_last = (phase == PH_ADDR) && byte_done &&
                      (bidx == ADDR_BYTES - 2'h1);
   assign mode_done = (phase == PH_MODE) && byte_done;
   // R17 one dummy single-bit, R18 two quad
   assign dummy_need = quad ? QUAD_DUMMY_BYTES : SINGLE_DUMMY_BYTES;
   assign dummy_last = (phase == PH_DUMMY) && byte_done &&
                       (bidx == dummy_need - 2'h1);
   // R10 plain read streams with no dummy
   assign enter_data = (addr_last && !fast) || dummy_last;
   assign data_step = (phase == PH_DATA) && byte_done;

   // Phase sequencing
   always_comb
   begin
      next_phase = phase;
      case (phase)
         PH_FIRST:
         begin
            if (cont_addr || start_read || start_fast)
            begin
               next_phase = PH_ADDR;
            end
            else if (byte_done)
            begin
               next_phase = PH_IGNORE;
            end
         end
         PH_ADDR:
         begin
            if (addr_last)
            begin
               if (!fast)
               begin
                  next_phase = PH_DATA;
               end
               else if (quad)
               begin
                  next_phase = PH_MODE;
               end
               else
               begin
                  next_phase = PH_DUMMY;
               end
            end
         end
         PH_MODE:
         begin
            if (mode_done)
            begin
               next_phase = PH_DUMMY;
            end
         end
         PH_DUMMY:
         begin
            if (dummy_last)
            begin
               next_phase = PH_DATA;
            end
         end
         PH_DATA:
         begin
            next_phase = PH_DATA;
         end
         default:
         begin
            next_phase = PH_IGNORE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Read address and data path
   ////////////////////////////////////////////////////////////////////////

   // R3 upper address bits dropped
   // R12 increment wraps to zero
   assign rd_addr = data_step ? ptr + ARRAY_AW'(1)
                  : (phase == PH_ADDR) ? addr_next[ARRAY_AW-1:0] : ptr;
   assign rd_en = enter_data || data_step;

   // R20 locked bytes read as zero
   assign byte_out = (lock_q && quad) ? LOCKED_DATA : mem_rdata;

   flash_array_mem #(.AW(ARRAY_AW), .DW(8)) u_mem
   (
      .wr_clk(mclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .rd_clk(sck),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Frame logic on rising sck
   ////////////////////////////////////////////////////////////////////////

   // R24 sample on rising edge, select rise abandons the frame
   always_ff @(posedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         phase <= PH_FIRST;
         bcnt <= 3'h0;
         shreg <= 8'h00;
      end
      else
      begin
         phase <= next_phase;
         bcnt <= byte_done ? 3'h0 : bcnt + 3'h1;
         shreg <= byte_w;
      end
   end

   // Byte index within address and dummy runs
   always_ff @(posedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         bidx <= 2'h0;
      end
      else if (byte_done)
      begin
         bidx <= (cont_addr || phase == PH_DUMMY) ? bidx + 2'h1
               : (phase == PH_ADDR && !addr_last) ? bidx + 2'h1 : 2'h0;
      end
   end

   // Address capture and read kind
   always_ff @(posedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         fast <= 1'b0;
         addr_acc <= 24'h000000;
      end
      else
      begin
         if (start_fast || cont_addr)
         begin
            fast <= 1'b1;
         end
         if (byte_done && (phase == PH_FIRST || phase == PH_ADDR))
         begin
            addr_acc <= addr_next;
         end
      end
   end

   // R12 pointer follows each streamed byte
   always_ff @(posedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         ptr <= '0;
         lock_q <= 1'b0;
      end
      else
      begin
         if (addr_last || data_step)
         begin
            ptr <= rd_addr;
         end
         if (rd_en)
         begin
            lock_q <= lock_sync[rd_addr[ARRAY_AW-1:LOCK_BLOCK_AW]];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protocol state kept across frames
   ////////////////////////////////////////////////////////////////////////

   // R23 single-bit after power-up
   // R4 arm cleared by any other opcode
   // R6 no-operation only drops the arm
   always_ff @(posedge sck)
   begin
      if (link_rst)
      begin
         arm <= 1'b0;
         rst_tgl <= 1'b0;
      end
      else
      begin
         if (is_cmd)
         begin
            arm <= exec_arm;
         end
         if (exec_reset)
         begin
            rst_tgl <= ~rst_tgl;
         end
      end
   end

   // R7 reset falls back to single-bit
   // R13 quad until exit, R14 exit command
   always_ff @(posedge sck)
   begin
      if (link_rst)
      begin
         quad <= 1'b0;
      end
      else if (exec_reset || exec_quad_exit)
      begin
         quad <= 1'b0;
      end
      else if (exec_quad_en)
      begin
         quad <= 1'b1;
      end
   end

   // R21 nibble A keeps continuous mode, R22 otherwise leave
   always_ff @(posedge sck)
   begin
      if (link_rst || exec_reset || cont_exit)
      begin
         cont <= 1'b0;
      end
      else if (mode_done)
      begin
         cont <= (byte_w[7:4] == CONT_MODE_NIBBLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output drive on falling sck
   ////////////////////////////////////////////////////////////////////////

   // R19 launch on falling edge
   // R11 select rise releases the lines at once
   always_ff @(negedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
      begin
         serial_io_lines_out <= 4'h0;
         serial_io_lines_oe <= 4'h0;
      end
      else if (phase == PH_DATA)
      begin
         serial_io_lines_out <= out_lines(byte_out, bcnt, quad);
         serial_io_lines_oe <= quad ? 4'hF : 4'h2;
      end
      else
      begin
         serial_io_lines_out <= 4'h0;
         serial_io_lines_oe <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System domain: reset event and registers
   ////////////////////////////////////////////////////////////////////////

   logic rst_tgl_s;
   logic rst_tgl_d;
   wire sw_evt;
   wire [7:0] next_status;
   wire [7:0] next_config;
   wire [1:0] next_burst;

   // Reset event crosses as a toggle
   sync2 #(.WIDTH(1)) u_rst_sync
   (
      .clk(mclk),
      .d(rst_tgl),
      .q(rst_tgl_s)
   );

   // Protocol level seen by the system side
   sync2 #(.WIDTH(1)) u_quad_sync
   (
      .clk(mclk),
      .d(quad),
      .q(quad_mode)
   );

   assign sw_evt = rst_tgl_s ^ rst_tgl_d;

   // R7 register defaults on reset; reset beats a same-cycle write
   assign next_status = sw_evt ? ((status_reg & STATUS_KEEP_MASK) |
                                  (STATUS_RESET & ~STATUS_KEEP_MASK))
                      : status_we ? status_wdata : status_reg;
   assign next_config = sw_evt ? (config_reg & ~CONFIG_IO_MASK)
                      : config_we ? config_wdata : config_reg;
   assign next_burst = sw_evt ? BURST_RESET
                     : burst_we ? burst_wdata : burst_len;

   // Registers and event pulses
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rst_tgl_d <= 1'b0;
         status_reg <= STATUS_RESET;
         config_reg <= CONFIG_RESET;
         burst_len <= BURST_RESET;
         sw_reset_pulse <= 1'b0;
         abort_program <= 1'b0;
      end
      else
      begin
         rst_tgl_d <= rst_tgl_s;
         status_reg <= next_status;
         config_reg <= next_config;
         burst_len <= next_burst;
         sw_reset_pulse <= sw_evt;
         // R8 abort a running program or erase
         abort_program <= sw_evt && program_busy;
      end
   end

endmodule
`default_nettype wire

// ---- tb/flash_cmd_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_monitor
(
   // Clocks and reset
   input wire logic mclk,
   input wire logic srst,
   input wire logic sck,
   // Link
   input wire logic chip_sel_n,
   input wire logic [3:0] serial_io_lines_oe,
   // Registers and events
   input wire logic status_we,
   input wire logic [7:0] status_wdata,
   input wire logic [7:0] status_reg,
   input wire logic [7:0] config_reg,
   input wire logic [1:0] burst_len,
   input wire logic quad_mode,
   input wire logic sw_reset_pulse,
   input wire logic abort_program
);
   logic [5:0] edge_cnt;

   ////////////////////////////////////////////////////////////
   // Rising sck edges in this frame
   always_ff @(posedge sck or posedge chip_sel_n)
   begin
      if (chip_sel_n)
         edge_cnt <= 6'h00;
      else if (edge_cnt != 6'h3F)
         edge_cnt <= edge_cnt + 6'h01;
   end

   ////////////////////////////////////////////////////////////
   // Register side
   sequence s_lone_write;
      (status_we && !srst) ##1 !sw_reset_pulse;
   endsequence
   property p_status_write;
      @(posedge mclk) disable iff (srst)
      s_lone_write |-> status_reg == $past(status_wdata);
   endproperty
   a_status_write: assert property (p_status_write)
      else $error("status write lost");
   property p_reset_pulse;
      @(posedge mclk) disable iff (srst) sw_reset_pulse |=> !sw_reset_pulse;
   endproperty
   a_reset_pulse: assert property (p_reset_pulse)
      else $error("reset pulse too long");
   property p_reset_values;
      @(posedge mclk) disable iff (srst)
      sw_reset_pulse |-> ##[0:1] (burst_len == 2'h0 && !config_reg[1]
         && (status_reg & 8'hCF) == 8'h00);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("registers not restored");
   property p_abort;
      @(posedge mclk) disable iff (srst) abort_program |-> sw_reset_pulse;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort without reset");

   ////////////////////////////////////////////////////////////
   // Link side: quiet until data
   property p_deselect_quiet;
      @(posedge mclk) disable iff (srst)
      chip_sel_n |-> serial_io_lines_oe == 4'h0;
   endproperty
   a_deselect_quiet: assert property (p_deselect_quiet)
      else $error("drive while deselected");
   property p_quad_gap;
      @(posedge sck) disable iff (srst)
      !chip_sel_n && edge_cnt < 6'h0C |-> serial_io_lines_oe == 4'h0;
   endproperty
   a_quad_gap: assert property (p_quad_gap)
      else $error("drive before dummy end");
   property p_single_gap;
      @(posedge sck) disable iff (srst)
      !chip_sel_n && !quad_mode && edge_cnt < 6'h20
         |-> serial_io_lines_oe == 4'h0;
   endproperty
   a_single_gap: assert property (p_single_gap)
      else $error("drive before address end");
   property p_oe_shape;
      @(posedge sck) disable iff (srst) serial_io_lines_oe != 4'h0
         |-> serial_io_lines_oe == (quad_mode ? 4'hF : 4'h2);
   endproperty
   a_oe_shape: assert property (p_oe_shape)
      else $error("wrong lines driven");
endmodule
`default_nettype wire

// ---- tb/flash_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_host_model
(
   // Link clock and select
   output logic sck,
   output logic chip_sel_n,
   // Wire level seen by the device
   output logic [3:0] serial_io_lines_in,
   // Device drive
   input wire logic [3:0] serial_io_lines_out,
   input wire logic [3:0] serial_io_lines_oe
);
   logic quad;
   logic [3:0] host_val;

   // Device drive wins
   assign serial_io_lines_in = (serial_io_lines_oe & serial_io_lines_out)
      | (~serial_io_lines_oe & host_val);

   // Idle: clock low, deselected
   initial
   begin
      sck = 1'b0;
      chip_sel_n = 1'b1;
      quad = 1'b0;
      host_val = 4'hF;
   end

   ////////////////////////////////////////////////////////////
   // data moves after falling edge
   task automatic tick;
      #24 sck = 1'b1;
      #24 sck = 1'b0;
   endtask
   task automatic open_frame;
      #24 chip_sel_n = 1'b0;
   endtask
   task automatic close_frame;
      #24 chip_sel_n = 1'b1;
      #48;
   endtask
   task automatic put(input logic [7:0] b);
      int i;
      if (quad)
      begin
         host_val = b[7:4];
         tick;
         host_val = b[3:0];
         tick;
      end
      else
         for (i = 7; i >= 0; i--)
         begin
            host_val = {3'h7, b[i]};
            tick;
         end
   endtask
   task automatic get(output logic [7:0] b);
      int i;
      for (i = 0; i < (quad ? 2 : 8); i++)
      begin
         host_val = ~host_val;
         #24 sck = 1'b1;
         b = quad ? {b[3:0], serial_io_lines_in}
            : {b[6:0], serial_io_lines_in[1]};
         #24 sck = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/serial_flash_command_front_end_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_test;
   import flash_cmd_pkg::*;
   logic mclk, srst, mem_we, program_busy, status_we, config_we, burst_we;
   logic [16:0] mem_waddr;
   logic [7:0] mem_wdata, status_wdata, config_wdata, got [4];
   logic [1:0] read_lock, burst_wdata, burst_len;
   logic [7:0] status_reg, config_reg;
   logic quad_mode, sw_reset_pulse, abort_program, sck, chip_sel_n;
   logic [3:0] serial_io_lines_in, serial_io_lines_out, serial_io_lines_oe;
   int error_cnt, samples_checked, rst_seen, abort_seen, drove, cycles;

   flash_cmd_front_end #(.ARRAY_AW(17), .LOCK_BLOCKS(2)) dut (.*);
   flash_host_model host (.*);

   ////////////////////////////////////////////////////////////
   // 250 MHz system clock
   always #2 mclk = ~mclk;
   // Tallies and watchdog
   always @(posedge mclk)
   begin
      rst_seen += int'(sw_reset_pulse === 1'b1);
      abort_seen += int'(abort_program === 1'b1);
      cycles++;
      if (cycles == 40000)
      begin
         error_cnt++;
         $display("BAD %0t watchdog", $time);
         results;
      end
   end
   always @(posedge sck)
      drove += int'(serial_io_lines_oe !== 4'h0);

   ////////////////////////////////////////////////////////////
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, string m);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   function automatic logic [7:0] pat(input logic [16:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   task automatic load(input logic [16:0] a);
      @(negedge mclk);
      mem_we = 1'b1;
      mem_waddr = a;
      mem_wdata = pat(a);
      @(negedge mclk);
      mem_we = 1'b0;
   endtask
   task automatic cmd(input logic [7:0] op);
      host.open_frame;
      host.put(op);
      host.close_frame;
   endtask
   // Opcode, address, pad (mode first), n data
   task automatic rd(input logic use_op, input logic [7:0] op,
      input logic [23:0] a, input int pad, input logic [7:0] mode, int n);
      int i;
      host.open_frame;
      if (use_op)
         host.put(op);
      for (i = 2; i >= 0; i--)
         host.put(a[8*i +: 8]);
      for (i = 0; i < pad; i++)
         host.put(i == 0 ? mode : 8'h00);
      for (i = 0; i < n; i++)
         host.get(got[i]);
      host.close_frame;
   endtask
   task automatic wait_quad(input logic v);
      int n;
      for (n = 0; n < 100 && quad_mode !== v; n++)
         @(negedge mclk);
      chk({7'h00, quad_mode}, {7'h00, v}, "quad mode");
   endtask

   ////////////////////////////////////////////////////////////
   // Cut frame, plain read with wrap, fast read
   task automatic t_single_reads;
      int i;
      host.open_frame;
      host.put(READ_COMMAND);
      host.put(8'h00);
      host.close_frame;
      rd(1'b1, READ_COMMAND, 24'hFFFFFE, 0, 8'h00, 4);
      for (i = 0; i < 4; i++)
         chk(got[i], pat(17'h1FFFE + 17'(i)), "plain read");
      rd(1'b1, FAST_READ_COMMAND, 24'h000000, 1, 8'hC3, 3);
      for (i = 0; i < 3; i++)
         chk(got[i], pat(17'(i)), "fast read");
   endtask
   // Reset arming and restore
   task automatic t_reset;
      @(negedge mclk);
      {status_we, config_we, burst_we} = 3'h7;
      {status_wdata, config_wdata, burst_wdata} = {16'hFFFF, 2'h3};
      @(negedge mclk);
      {status_we, config_we, burst_we} = 3'h0;
      chk(status_reg, 8'hFF, "status write");
      rst_seen = 0;
      cmd(RESET_ARM_COMMAND);
      cmd(NOP_COMMAND);
      cmd(RESET_COMMAND);
      repeat (20) @(negedge mclk);
      chk(rst_seen[7:0], 8'h00, "no-op reset");
      program_busy = 1'b1;
      cmd(RESET_ARM_COMMAND);
      cmd(RESET_COMMAND);
      repeat (20) @(negedge mclk);
      program_busy = 1'b0;
      chk(rst_seen[7:0], 8'h01, "reset count");
      chk(abort_seen[7:0], 8'h01, "abort count");
      chk(status_reg, 8'h30, "status reset");
      chk(config_reg, 8'hFD, "config reset");
      chk({6'h00, burst_len}, 8'h00, "burst reset");
   endtask
   // Quad entry, lock, continuous frame, exit
   task automatic t_quad;
      cmd(QUAD_ENABLE_COMMAND);
      wait_quad(1'b1);
      host.quad = 1'b1;
      drove = 0;
      rd(1'b1, READ_COMMAND, 24'h000000, 0, 8'h00, 2);
      chk(drove[7:0], 8'h00, "plain read in quad");
      rd(1'b1, FAST_READ_COMMAND, 24'h01FFFF, 3, 8'hA5, 2);
      chk(got[0], LOCKED_DATA, "locked byte");
      chk(got[1], pat(17'h00000), "quad wrap");
      rd(1'b0, 8'h00, 24'h000001, 3, 8'hA0, 1);
      chk(got[0], pat(17'h00001), "continuous frame");
      cmd(QUAD_EXIT_COMMAND);
      repeat (20) @(negedge mclk);
      chk({7'h00, quad_mode}, 8'h01, "first exit");
      rd(1'b1, FAST_READ_COMMAND, 24'h000002, 3, 8'h00, 1);
      chk(got[0], pat(17'h00002), "opcode after exit");
      cmd(QUAD_EXIT_COMMAND);
      wait_quad(1'b0);
      host.quad = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////
   // Reset held over link settling edges
   initial
   begin
      {mclk, srst, mem_we, program_busy} = 4'h4;
      {status_we, config_we, burst_we} = 3'h0;
      {mem_waddr, mem_wdata, status_wdata, config_wdata} = 41'h0;
      {burst_wdata, read_lock} = 4'h2;
      repeat (4) host.tick;
      @(negedge mclk);
      srst = 1'b0;
      repeat (3) host.tick;
      chk({7'h00, quad_mode}, 8'h00, "power-up");
      for (int k = -2; k < 3; k++)
         load(17'(k));
      t_single_reads;
      t_reset;
      t_quad;
      results;
   end
endmodule

bind flash_cmd_front_end flash_cmd_monitor mon (.*);
`default_nettype wire
